// ===== sim/bts_far_model.sv
// Far-side model: generator half-period ticks, aux sync and the external jack.
`timescale 1ns/1ns
module bts_far_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Jack control from the bench
    input wire logic jack_drive,
    input wire logic jack_level,
    // Lines into the sequencer
    output logic external_trigger_jack,
    output logic aux_sync,
    output logic half_period_tick
);
    logic [2:0] cnt_q;
    // The jack floats high through its pull-up when nothing drives it.
    assign external_trigger_jack = jack_drive ? jack_level : 1'h1;
    assign half_period_tick = cnt_q[1:0] == 2'h3;
    assign aux_sync = cnt_q[2];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 3'h0;
        else
            cnt_q <= cnt_q + 3'h1;
    end
endmodule

// ===== sim/bts_sequencer_assertions.sv
// Port checker for the sequencer.
`timescale 1ns/1ns
module bts_sequencer_assertions
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Generator controls
    input wire logic [2:0] main_shape,
    input wire logic [2:0] aux_shape,
    input wire logic [7:0] duty_hw,
    input wire logic fixed_duty_indication,
    input wire logic var_freq_cap,
    input wire logic amp_to_pp,
    input wire logic main_run,
    input wire logic aux_run
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_main_code_range: assert property (main_shape <= 3'h6) else $error("main shape out of range");
    a_aux_code_range: assert property (aux_shape inside {[3'h1:3'h5]}) else $error("aux shape out of range");
    a_aux_free_run: assert property ($past(presetn) |-> aux_run) else $error("aux channel stopped");
    a_duty_hw_range: assert property (duty_hw inside {[8'h0c:8'hf3]}) else $error("duty outside 5 to 95");
    a_fixed_half_code: assert property ($rose(fixed_duty_indication) |-> ##[0:2] duty_hw == 8'h80)
        else $error("fixed duty not half");
    a_cap_var_only: assert property ($rose(var_freq_cap) |-> ##[0:1] !fixed_duty_indication)
        else $error("cap raised in fixed mode");
    a_cap_fixed_off: assert property (fixed_duty_indication && $past(fixed_duty_indication) |-> !var_freq_cap)
        else $error("cap held in fixed mode");
    a_amp_pulse_short: assert property (amp_to_pp |=> !amp_to_pp) else $error("unit pulse too long");
    cover property ($fell(main_run));
    cover property ($rose(fixed_duty_indication));
    cover property (amp_to_pp);
endmodule
bind bts_sequencer bts_sequencer_assertions chk (.pclk, .presetn, .main_shape, .aux_shape, .duty_hw,
    .fixed_duty_indication, .var_freq_cap, .amp_to_pp, .main_run, .aux_run);

// ===== sim/bts_sequencer_test.sv
// Bench: register, duty and oscillation mode scenarios for the sequencer.
`timescale 1ns/1ns
module bts_sequencer_test;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, jd = 1'h0, jl = 1'h0;
    logic [7:0] paddr = 8'h00, duty_hw;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] main_shape, aux_shape;
    logic pready, pslverr, er, ext, aux_sync, tick, fixed, sq, cap, amp, main_run, aux_run;
    logic [31:0] st[4] = '{32'h506, 32'h100, 32'h506, 32'h106};
    logic [31:0] ex[4] = '{32'h500, 32'h106, 32'h106, 32'h506};
    int fails = 0, check_count = 0;
    bts_far_model far (.pclk, .presetn, .jack_drive(jd), .jack_level(jl), .external_trigger_jack(ext),
        .aux_sync, .half_period_tick(tick));
    bts_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_trigger_jack(ext), .aux_sync, .half_period_tick(tick), .main_shape, .aux_shape, .duty_hw,
        .fixed_duty_indication(fixed), .square_duty_active(sq), .var_freq_cap(cap), .amp_to_pp(amp),
        .main_run, .aux_run);
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    task stop_test(input bit hung);
        fails += hung;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        for (n = 0; pready !== 1'h1 && n < 20; n++)
            @(posedge pclk);
        if (n == 20)
            stop_test(1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask
    task run_is(input logic v, input int b);
        int n;
        for (n = 0; main_run !== v && n < b; n++)
            @(posedge pclk);
        if (n == b)
            stop_test(1);
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        chk("aux_run", 1, aux_run);
        chk("fixed", 1, fixed);
        bus(0, bts_pkg::OFS_SHAPE, 0);
        chk("shape", 32'h101, rd);
        for (int i = 0; i < 4; i++)
        begin
            bus(1, bts_pkg::OFS_SHAPE, st[i]);
            bus(1, bts_pkg::OFS_CMD, 32'h1 << i);
            bus(0, bts_pkg::OFS_SHAPE, 0);
            chk("shape", ex[i], rd);
        end
        for (int i = 0; i < 2; i++)
        begin
            bus(1, bts_pkg::OFS_MODE, 3 - 3 * i);
            bus(1, bts_pkg::OFS_CMD, 32'h10 << i);
            bus(0, bts_pkg::OFS_MODE, 0);
            chk("mode", 3 * i, rd[1:0]);
        end
        bus(0, 8'h40, 0);
        chk("unmapped err", 1, er);
        bus(1, bts_pkg::OFS_SHAPE, 32'h101);
        bus(1, bts_pkg::OFS_AMPL, 32'h10064);
        bus(1, bts_pkg::OFS_SHAPE, 32'h103);
        chk("square", 1, sq);
        bus(0, bts_pkg::OFS_AMPL, 0);
        chk("unit", 0, rd[17:16]);
        chk("ampl", 32'h64, rd[15:0]);
        bus(1, bts_pkg::OFS_DUTY, 100);
        bus(0, bts_pkg::OFS_DUTY, 0);
        chk("duty", 32'h19000064, rd);
        chk("cap", 1, cap);
        bus(1, bts_pkg::OFS_DUTY, 101);
        chk("duty_hw", 8'h19, duty_hw);
        bus(1, bts_pkg::OFS_DUTY, 20);
        bus(0, bts_pkg::OFS_DUTY, 0);
        chk("duty", 32'h0c000032, rd);
        bus(1, bts_pkg::OFS_CMD, 32'h40);
        chk("duty_hw", 8'h80, duty_hw);
        chk("cap", 0, cap);
        bus(1, bts_pkg::OFS_DUTY, 500);
        chk("fixed", 0, fixed);
        bus(1, bts_pkg::OFS_SHAPE, 32'h101);
        bus(1, bts_pkg::OFS_DUTY, 300);
        bus(0, bts_pkg::OFS_DUTY, 0);
        chk("duty", 300, rd[9:0]);
        chk("cap", 0, cap);
        bus(1, bts_pkg::OFS_MARK, 0);
        bus(0, bts_pkg::OFS_MARK, 0);
        chk("mark", 1, rd);
        bus(1, bts_pkg::OFS_MARK, 2);
        bus(1, bts_pkg::OFS_SPACE, 2);
        bus(1, bts_pkg::OFS_MODE, 1);
        run_is(0, 40);
        run_is(1, 40);
        run_is(0, 40);
        jd <= 1'h1;
        bus(1, bts_pkg::OFS_MODE, 0);
        run_is(1, 10);
        repeat (20) @(negedge pclk) chk("run", 1, main_run);
        bus(1, bts_pkg::OFS_MARK, 6);
        bus(1, bts_pkg::OFS_MODE, 2);
        run_is(0, 10);
        jl <= 1'h1;
        run_is(1, 10);
        jl <= 1'h0;
        repeat (2) @(posedge pclk);
        jl <= 1'h1;
        run_is(0, 24);
        repeat (12) @(negedge pclk) chk("run", 0, main_run);
        bus(1, bts_pkg::OFS_MODE, 32'h32);
        run_is(1, 30);
        bus(1, bts_pkg::OFS_MODE, 32'h23);
        run_is(0, 10);
        jl <= 1'h0;
        run_is(1, 20);
        jl <= 1'h1;
        run_is(0, 12);
        jd <= 1'h0;
        bus(1, bts_pkg::OFS_MODE, 3);
        run_is(1, 20);
        repeat (20) @(negedge pclk) chk("run", 1, main_run);
        stop_test(0);
    end
endmodule

// ===== verilog/bts_pkg.sv
// Package of constants and types for the burst trigger gate sequencer.
// Function
// - Main shape codes 0..6, aux codes 1..5, stepping wraps at both ends.
// - A written shape code takes effect at once; code 1 is sine.
// - AC to AC shape change keeps amplitude, converting its unit to peak-to-peak.
// - Duty only affects square code 3, yet is writable under any shape.
// - Variable duty accepts 5.0 to 95.0 percent; writing 50 stays variable.
// - Separate command selects fixed half duty; indication reports fixed or variable.
// - Applied duty is quantised to 8 bits; finer changes alter only shown value.
// - Variable-duty square is limited to at most 1 MHz.
// - Oscillation mode codes 0..3, 1 is burst, stepping wraps in unit steps.
// - Mode sequencing acts on main channel only; aux always runs free.
// - Continuous mode runs without pause, ignoring trigger, gate, mark and space.
// - Burst runs mark half-cycles then halts space half-cycles, repeating forever.
// - Each accepted trigger edge runs exactly mark count, then enters stopped state.
// - Trigger edges during a triggered run are discarded until stopped.
// - Gate going active while stopped starts oscillation, continuing while active.
// - Inactive gate stops only at the next half-period boundary.
// - Trigger source selects external jack or aux sync, each with polarity.
// - Trigger mode accepts rising or falling edges per polarity setting.
// - Gate mode treats high or low level as active per polarity.
// - Unconnected external jack reads high, so rising gate runs continuously.
// - Mark and space span 0.5 to 32768.0 cycles in half-cycle steps.
// - Mark shared by burst and trigger, space burst only, both always writable.
package bts_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_SHAPE = 8'h00;
    localparam logic [7:0] OFS_DUTY = 8'h04;
    localparam logic [7:0] OFS_MODE = 8'h08;
    localparam logic [7:0] OFS_MARK = 8'h0c;
    localparam logic [7:0] OFS_SPACE = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_AMPL = 8'h1c;

    // Field positions.
    localparam int SHAPE_AUX_LSB = 8;
    localparam int DUTY_FIXED_BIT = 16;
    localparam int DUTY_HW_LSB = 24;
    localparam int MODE_SRC_BIT = 4;
    localparam int MODE_POL_BIT = 5;
    localparam int AMPL_UNIT_LSB = 16;
    localparam int CMD_MAIN_UP = 0;
    localparam int CMD_MAIN_DN = 1;
    localparam int CMD_AUX_UP = 2;
    localparam int CMD_AUX_DN = 3;
    localparam int CMD_MODE_UP = 4;
    localparam int CMD_MODE_DN = 5;
    localparam int CMD_FIXED_HALF = 6;

    // Shape codes and ranges.
    localparam logic [2:0] MAIN_SHAPE_MIN = 3'h0;
    localparam logic [2:0] MAIN_SHAPE_MAX = 3'h6;
    localparam logic [2:0] AUX_SHAPE_MIN = 3'h1;
    localparam logic [2:0] AUX_SHAPE_MAX = 3'h5;
    localparam logic [2:0] SHAPE_DC = 3'h0;
    localparam logic [2:0] SHAPE_SINE = 3'h1;
    localparam logic [2:0] SHAPE_SQUARE = 3'h3;
    localparam logic [2:0] SHAPE_ARBITRARY = 3'h6;

    // Duty in tenths of a percent, and its 8-bit quantiser (x*262 >> 10 ~ x*256/1000).
    localparam logic [9:0] DUTY_MIN = 10'h032;
    localparam logic [9:0] DUTY_MAX = 10'h3b6;
    localparam logic [9:0] DUTY_HALF = 10'h1f4;
    localparam logic [8:0] DUTY_QUANT_MUL = 9'h106;
    localparam int DUTY_QUANT_SHIFT = 10;
    localparam int VAR_FREQ_MAX_HZ = 1000000;

    // Mark and space are held as half-cycles minus one: 0.5 .. 32768.0 cycles.
    localparam logic [16:0] HALF_MIN = 17'h00001;
    localparam logic [16:0] HALF_MAX = 17'h10000;
    localparam logic [15:0] MARK_RST = 16'h0001;
    localparam logic [15:0] SPACE_RST = 16'h0001;

    // Amplitude units.
    localparam logic [1:0] UNIT_PP = 2'h0;

    // Reset values.
    localparam logic [2:0] MAIN_SHAPE_RST = SHAPE_SINE;
    localparam logic [2:0] AUX_SHAPE_RST = SHAPE_SINE;
    localparam logic [9:0] DUTY_RST = DUTY_HALF;

    typedef enum logic [1:0]
    {
        MODE_CONT = 2'h0,
        MODE_BURST = 2'h1,
        MODE_TRIG = 2'h2,
        MODE_GATE = 2'h3
    } bts_mode_e;

    typedef enum logic [1:0]
    {
        ST_STOP = 2'b00,
        ST_MARK = 2'b01,
        ST_SPACE = 2'b11
    } bts_state_e;

    typedef struct packed
    {
        bts_mode_e mode;
        logic src_aux;
        logic pol_falling;
    } bts_osc_cfg_s;

endpackage

// ===== verilog/bts_sequencer.sv
// Shape, duty and oscillation mode control with an APB register slave.
`timescale 1ns/1ns
module bts_sequencer
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger inputs and generator timing
    input wire logic external_trigger_jack,
    input wire logic aux_sync,
    input wire logic half_period_tick,
    // Generator controls
    output logic [2:0] main_shape,
    output logic [2:0] aux_shape,
    output logic [7:0] duty_hw,
    output logic fixed_duty_indication,
    output logic square_duty_active,
    output logic var_freq_cap,
    output logic amp_to_pp,
    output logic main_run,
    output logic aux_run
);

    //--------------------------------------------------------------------
    // Register state
    //--------------------------------------------------------------------
    logic [2:0] main_shape_q;
    logic [2:0] aux_shape_q;
    logic [9:0] duty_q;
    logic fixed_q;
    bts_pkg::bts_osc_cfg_s cfg_q;
    logic [15:0] mark_q;
    logic [15:0] space_q;
    logic [15:0] ampl_q;
    logic [1:0] unit_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic amp_to_pp_q;

    logic setup;
    logic wr_en;
    logic [2:0] main_shape_d;
    logic [2:0] aux_shape_d;
    logic [16:0] wr_half;
    logic [15:0] wr_half_m1;
    logic [9:0] wr_duty;
    logic mapped;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_q;
    assign wr_half = pwdata[16:0];
    assign wr_duty = pwdata[9:0];

    // Half-cycle counts are clamped into range and stored minus one.
    always_comb
    begin
        if (wr_half < bts_pkg::HALF_MIN)
        begin
            wr_half_m1 = 16'h0000;
        end
        else if (wr_half > bts_pkg::HALF_MAX)
        begin
            wr_half_m1 = 16'hffff;
        end
        else
        begin
            wr_half_m1 = 16'(wr_half - 17'h00001);
        end
    end

    //--------------------------------------------------------------------
    // Shape selection
    //--------------------------------------------------------------------
    always_comb
    begin
        main_shape_d = main_shape_q;
        aux_shape_d = aux_shape_q;
        if (wr_en && paddr == bts_pkg::OFS_SHAPE)
        begin
            // Out-of-range codes are ignored and the old shape is kept.
            if (pwdata[2:0] <= bts_pkg::MAIN_SHAPE_MAX)
            begin
                main_shape_d = pwdata[2:0];
            end
            if (pwdata[bts_pkg::SHAPE_AUX_LSB+:3] >= bts_pkg::AUX_SHAPE_MIN &&
                pwdata[bts_pkg::SHAPE_AUX_LSB+:3] <= bts_pkg::AUX_SHAPE_MAX)
            begin
                aux_shape_d = pwdata[bts_pkg::SHAPE_AUX_LSB+:3];
            end
        end
        else if (wr_en && paddr == bts_pkg::OFS_CMD)
        begin
            if (pwdata[bts_pkg::CMD_MAIN_UP])
            begin
                main_shape_d = (main_shape_q == bts_pkg::MAIN_SHAPE_MAX) ?
                    bts_pkg::MAIN_SHAPE_MIN : 3'(main_shape_q + 3'h1);
            end
            else if (pwdata[bts_pkg::CMD_MAIN_DN])
            begin
                main_shape_d = (main_shape_q == bts_pkg::MAIN_SHAPE_MIN) ?
                    bts_pkg::MAIN_SHAPE_MAX : 3'(main_shape_q - 3'h1);
            end
            if (pwdata[bts_pkg::CMD_AUX_UP])
            begin
                aux_shape_d = (aux_shape_q == bts_pkg::AUX_SHAPE_MAX) ?
                    bts_pkg::AUX_SHAPE_MIN : 3'(aux_shape_q + 3'h1);
            end
            else if (pwdata[bts_pkg::CMD_AUX_DN])
            begin
                aux_shape_d = (aux_shape_q == bts_pkg::AUX_SHAPE_MIN) ?
                    bts_pkg::AUX_SHAPE_MAX : 3'(aux_shape_q - 3'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_shape_q <= bts_pkg::MAIN_SHAPE_RST;
            aux_shape_q <= bts_pkg::AUX_SHAPE_RST;
        end
        else
        begin
            main_shape_q <= main_shape_d;
            aux_shape_q <= aux_shape_d;
        end
    end

    //--------------------------------------------------------------------
    // Amplitude holding
    //--------------------------------------------------------------------
    // Between AC shapes the stored value is kept; a non peak-to-peak unit is
    // turned to peak-to-peak and the converter is asked to rescale the value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ampl_q <= 16'h0000;
            unit_q <= bts_pkg::UNIT_PP;
            amp_to_pp_q <= 1'b0;
        end
        else
        begin
            amp_to_pp_q <= 1'b0;
            if (main_shape_d != main_shape_q && main_shape_d != bts_pkg::SHAPE_DC &&
                main_shape_q != bts_pkg::SHAPE_DC && unit_q != bts_pkg::UNIT_PP)
            begin
                unit_q <= bts_pkg::UNIT_PP;
                amp_to_pp_q <= 1'b1;
            end
            else if (wr_en && paddr == bts_pkg::OFS_AMPL)
            begin
                ampl_q <= pwdata[15:0];
                unit_q <= pwdata[bts_pkg::AMPL_UNIT_LSB+:2];
            end
        end
    end

    //--------------------------------------------------------------------
    // Duty cycle
    //--------------------------------------------------------------------
    logic [18:0] duty_prod;
    assign duty_prod = duty_q * bts_pkg::DUTY_QUANT_MUL;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_q <= bts_pkg::DUTY_RST;
            fixed_q <= 1'b1;
        end
        else if (wr_en && paddr == bts_pkg::OFS_CMD && pwdata[bts_pkg::CMD_FIXED_HALF])
        begin
            fixed_q <= 1'b1;
        end
        else if (wr_en && paddr == bts_pkg::OFS_DUTY)
        begin
            // Writable under every shape; writing 50.0 still means variable.
            fixed_q <= 1'b0;
            if (wr_duty < bts_pkg::DUTY_MIN)
            begin
                duty_q <= bts_pkg::DUTY_MIN;
            end
            else if (wr_duty > bts_pkg::DUTY_MAX)
            begin
                duty_q <= bts_pkg::DUTY_MAX;
            end
            else
            begin
                duty_q <= wr_duty;
            end
        end
    end

    // Only the quantised value reaches the generator.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_hw <= 8'h80;
            fixed_duty_indication <= 1'b1;
            square_duty_active <= 1'b0;
            var_freq_cap <= 1'b0;
        end
        else
        begin
            duty_hw <= fixed_q ? 8'h80 : duty_prod[bts_pkg::DUTY_QUANT_SHIFT+:8];
            fixed_duty_indication <= fixed_q;
            square_duty_active <= main_shape_q == bts_pkg::SHAPE_SQUARE;
            var_freq_cap <= main_shape_q == bts_pkg::SHAPE_SQUARE && !fixed_q;
        end
    end

    //--------------------------------------------------------------------
    // Mode, source, mark and space
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= '{mode: bts_pkg::MODE_CONT, src_aux: 1'b0, pol_falling: 1'b0};
            mark_q <= bts_pkg::MARK_RST;
            space_q <= bts_pkg::SPACE_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                bts_pkg::OFS_MODE:
                begin
                    cfg_q.mode <= bts_pkg::bts_mode_e'(pwdata[1:0]);
                    cfg_q.src_aux <= pwdata[bts_pkg::MODE_SRC_BIT];
                    cfg_q.pol_falling <= pwdata[bts_pkg::MODE_POL_BIT];
                end
                bts_pkg::OFS_CMD:
                begin
                    if (pwdata[bts_pkg::CMD_MODE_UP])
                    begin
                        cfg_q.mode <= bts_pkg::bts_mode_e'(2'(cfg_q.mode + 2'h1));
                    end
                    else if (pwdata[bts_pkg::CMD_MODE_DN])
                    begin
                        cfg_q.mode <= bts_pkg::bts_mode_e'(2'(cfg_q.mode - 2'h1));
                    end
                end
                bts_pkg::OFS_MARK:
                begin
                    mark_q <= wr_half_m1;
                end
                bts_pkg::OFS_SPACE:
                begin
                    space_q <= wr_half_m1;
                end
                default:
                begin
                end
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Trigger conditioning
    //--------------------------------------------------------------------
    // Flops start high, matching an open jack held high by its pull-up.
    logic ext_meta_q;
    logic ext_sync_q;
    logic src_q;
    logic src_lvl;
    logic trig_edge;
    logic gate_on;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_meta_q <= 1'b1;
            ext_sync_q <= 1'b1;
        end
        else
        begin
            ext_meta_q <= external_trigger_jack;
            ext_sync_q <= ext_meta_q;
        end
    end

    assign src_lvl = cfg_q.src_aux ? aux_sync : ext_sync_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_q <= 1'b1;
        end
        else
        begin
            src_q <= src_lvl;
        end
    end

    assign trig_edge = cfg_q.pol_falling ? (src_q && !src_lvl) : (!src_q && src_lvl);
    assign gate_on = cfg_q.pol_falling ? !src_lvl : src_lvl;

    //--------------------------------------------------------------------
    // Oscillation sequencer
    //--------------------------------------------------------------------
    bts_pkg::bts_state_e state_q;
    bts_pkg::bts_mode_e mode_prev_q;
    logic [15:0] cnt_q;
    logic mark_done;
    logic space_done;

    assign mark_done = half_period_tick && cnt_q == mark_q;
    assign space_done = half_period_tick && cnt_q == space_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= bts_pkg::ST_STOP;
            cnt_q <= 16'h0000;
            mode_prev_q <= bts_pkg::MODE_CONT;
        end
        else
        begin
            mode_prev_q <= cfg_q.mode;
            if (cfg_q.mode != mode_prev_q)
            begin
                state_q <= bts_pkg::ST_STOP;
                cnt_q <= 16'h0000;
            end
            else
            begin
                unique case (state_q)
                    bts_pkg::ST_STOP:
                    begin
                        cnt_q <= 16'h0000;
                        if (cfg_q.mode == bts_pkg::MODE_BURST ||
                            (cfg_q.mode == bts_pkg::MODE_TRIG && trig_edge) ||
                            (cfg_q.mode == bts_pkg::MODE_GATE && gate_on))
                        begin
                            state_q <= bts_pkg::ST_MARK;
                        end
                    end
                    bts_pkg::ST_MARK:
                    begin
                        // Trigger edges are not looked at while running.
                        if (cfg_q.mode == bts_pkg::MODE_GATE)
                        begin
                            if (half_period_tick && !gate_on)
                            begin
                                state_q <= bts_pkg::ST_STOP;
                            end
                        end
                        else if (mark_done)
                        begin
                            cnt_q <= 16'h0000;
                            state_q <= (cfg_q.mode == bts_pkg::MODE_BURST) ?
                                bts_pkg::ST_SPACE : bts_pkg::ST_STOP;
                        end
                        else if (half_period_tick)
                        begin
                            cnt_q <= 16'(cnt_q + 16'h0001);
                        end
                    end
                    bts_pkg::ST_SPACE:
                    begin
                        if (space_done)
                        begin
                            cnt_q <= 16'h0000;
                            state_q <= bts_pkg::ST_MARK;
                        end
                        else if (half_period_tick)
                        begin
                            cnt_q <= 16'(cnt_q + 16'h0001);
                        end
                    end
                    default:
                    begin
                        state_q <= bts_pkg::ST_STOP;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_run <= 1'b0;
            aux_run <= 1'b0;
        end
        else
        begin
            main_run <= cfg_q.mode == bts_pkg::MODE_CONT || state_q == bts_pkg::ST_MARK;
            aux_run <= 1'b1;
        end
    end

    //--------------------------------------------------------------------
    // APB read and answer
    //--------------------------------------------------------------------
    always_comb
    begin
        mapped = 1'b1;
        unique case (paddr)
            bts_pkg::OFS_SHAPE, bts_pkg::OFS_DUTY, bts_pkg::OFS_MODE, bts_pkg::OFS_MARK,
            bts_pkg::OFS_SPACE, bts_pkg::OFS_CMD, bts_pkg::OFS_STATUS, bts_pkg::OFS_AMPL:
            begin
                mapped = 1'b1;
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= 32'h00000000;
            if (!pwrite)
            begin
                unique case (paddr)
                    bts_pkg::OFS_SHAPE:
                        prdata_q <= {21'h000000, aux_shape_q, 5'h00, main_shape_q};
                    bts_pkg::OFS_DUTY:
                        prdata_q <= {duty_hw, 7'h00, fixed_q, 6'h00, duty_q};
                    bts_pkg::OFS_MODE:
                        prdata_q <= {26'h0000000, cfg_q.pol_falling, cfg_q.src_aux, 2'h0, cfg_q.mode};
                    bts_pkg::OFS_MARK:
                        prdata_q <= {15'h0000, 17'(mark_q) + 17'h00001};
                    bts_pkg::OFS_SPACE:
                        prdata_q <= {15'h0000, 17'(space_q) + 17'h00001};
                    bts_pkg::OFS_STATUS:
                        prdata_q <= {cnt_q, 12'h000, gate_on, main_run, state_q};
                    bts_pkg::OFS_AMPL:
                        prdata_q <= {14'h0000, unit_q, ampl_q};
                    default:
                        prdata_q <= 32'h00000000;
                endcase
            end
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign main_shape = main_shape_q;
    assign aux_shape = aux_shape_q;
    assign amp_to_pp = amp_to_pp_q;

endmodule
